// ==== verilog/down_timer_pkg.sv ====
/*
  constants shared by the prescaled down timer.
  assumes a single 200 MHz clock and a synchronous active-low reset.
*/
package down_timer_pkg;
  // field widths
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned PRESCALE_W = 4;
  // reset values
  localparam logic [COUNT_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'hffff;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RELOAD_RST = 4'h0;
  localparam logic STOP_RST = 1'b0;
  // counter terminal value
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 4'h0;
  // width of the output pin pulse, in clock cycles
  localparam int unsigned PULSE_CYCLES = 1;
endpackage

// ==== verilog/prescale_stage.sv ====
/*
  prescale counter: counts down, reloads from the divide-down value on a wrap
  or a reload request, and flags each wrap as a one-cycle tick.
  assumes the caller gates it with a run enable.
*/
`timescale 1ns/100ps
module prescale_stage (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic [down_timer_pkg::PRESCALE_W-1:0] reload_value_i,
  // status
  output logic [down_timer_pkg::PRESCALE_W-1:0] count_o,
  output logic wrap_o
);
  logic [down_timer_pkg::PRESCALE_W-1:0] count_q;

  // ==========================================================
  // wrap detect
  assign wrap_o = run_i && !reload_i && (count_q == down_timer_pkg::PRESCALE_ZERO);
  assign count_o = count_q;

  // ==========================================================
  // counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= down_timer_pkg::PRESCALE_RELOAD_RST;
    end else if (reload_i || wrap_o) begin
      count_q <= reload_value_i;
    end else if (run_i) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule

// ==== verilog/prescaled_down_timer.sv ====
/*
  prescaled down timer: prescale counter feeding a main down counter that
  reloads from the period value and raises an interrupt flag and pin pulse.
  assumes software drives the control ports synchronously to clk_i.
*/
`timescale 1ns/100ps
module prescaled_down_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // configuration writes
  input wire logic period_we_i,
  input wire logic [down_timer_pkg::COUNT_W-1:0] period_value_i,
  input wire logic prescale_reload_we_i,
  input wire logic [down_timer_pkg::PRESCALE_W-1:0] prescale_reload_i,
  input wire logic stop_bit_we_i,
  input wire logic stop_bit_i,
  input wire logic reload_bit_i,
  // interrupt flag clear
  input wire logic irq_flag_clear_i,
  // status
  output logic [down_timer_pkg::COUNT_W-1:0] main_count_o,
  output logic [down_timer_pkg::PRESCALE_W-1:0] prescale_counter_o,
  output logic [down_timer_pkg::COUNT_W-1:0] period_value_o,
  output logic [down_timer_pkg::PRESCALE_W-1:0] prescale_reload_o,
  output logic stop_bit_o,
  output logic reload_bit_o,
  output logic irq_flag_o,
  output logic timer_irq_o,
  output logic timer_pulse_out_o
);
  logic [down_timer_pkg::COUNT_W-1:0] period_q;
  logic [down_timer_pkg::PRESCALE_W-1:0] prescale_reload_q;
  logic stop_q;
  logic [down_timer_pkg::COUNT_W-1:0] main_count_q;
  logic irq_q;
  logic pulse_q;
  logic irq_flag_q;
  logic run;
  logic tick;
  logic main_wrap;

  // ==========================================================
  // control registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescale_reload_q <= down_timer_pkg::PRESCALE_RELOAD_RST;
    end else if (prescale_reload_we_i) begin
      prescale_reload_q <= prescale_reload_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      period_q <= down_timer_pkg::PERIOD_RST;
    end else if (period_we_i) begin
      period_q <= period_value_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stop_q <= down_timer_pkg::STOP_RST;
    end else if (stop_bit_we_i) begin
      stop_q <= stop_bit_i;
    end
  end

  assign run = !stop_q;

  // ==========================================================
  // prescaler
  prescale_stage u_prescale (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run),
    .reload_i(reload_bit_i),
    .reload_value_i(prescale_reload_q),
    .count_o(prescale_counter_o),
    .wrap_o(tick)
  );

  // ==========================================================
  // main counter
  assign main_wrap = tick && (main_count_q == down_timer_pkg::COUNT_ZERO);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_count_q <= down_timer_pkg::COUNT_RST;
    end else if (reload_bit_i) begin
      main_count_q <= period_q;
    end else if (main_wrap) begin
      main_count_q <= period_q;
    end else if (tick) begin
      main_count_q <= main_count_q - 1'b1;
    end
  end

  // ==========================================================
  // interrupt and pin pulse, one cycle after the wrap
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= main_wrap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= main_wrap;
    end
  end

  // set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_flag_q <= 1'b0;
    end else if (main_wrap) begin
      irq_flag_q <= 1'b1;
    end else if (irq_flag_clear_i) begin
      irq_flag_q <= 1'b0;
    end
  end

  assign main_count_o = main_count_q;
  assign period_value_o = period_q;
  assign prescale_reload_o = prescale_reload_q;
  assign stop_bit_o = stop_q;
  assign reload_bit_o = 1'b0;
  assign irq_flag_o = irq_flag_q;
  assign timer_irq_o = irq_q;
  assign timer_pulse_out_o = pulse_q;

  // ==========================================================
  // checks
  chk_irq_after_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    main_wrap |=> timer_irq_o)
    else $error("irq missing after main wrap");

  chk_irq_needs_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    timer_irq_o |-> $past(main_wrap))
    else $error("irq without main wrap");

  chk_pulse_tracks_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    timer_pulse_out_o == timer_irq_o)
    else $error("pin pulse differs from irq");

  chk_flag_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    main_wrap |=> irq_flag_o)
    else $error("irq flag not set");

  chk_reload_loads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reload_bit_i && !period_we_i |=> main_count_o == $past(period_q)
      && prescale_counter_o == $past(prescale_reload_q))
    else $error("reload did not load counters");

  chk_stop_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stop_q && !reload_bit_i |=> $stable(main_count_o) && $stable(prescale_counter_o) && !timer_irq_o)
    else $error("counters moved while stopped");

  chk_main_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick && !main_wrap && !reload_bit_i |=> main_count_o == $past(main_count_q) - 16'h0001)
    else $error("main count did not step once");

  chk_main_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    main_wrap && !period_we_i |=> main_count_o == $past(period_q))
    else $error("main count not reloaded at wrap");

  chk_prescale_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick && !prescale_reload_we_i |=> prescale_counter_o == $past(prescale_reload_q))
    else $error("prescaler not reloaded at wrap");

  chk_run_after_reset: assert property (@(posedge clk_i)
    !rst_n_i |=> stop_bit_o == down_timer_pkg::STOP_RST
      && prescale_reload_o == down_timer_pkg::PRESCALE_RELOAD_RST)
    else $error("stop bit or reload field wrong after reset");

  chk_pulse_after_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    main_wrap |=> timer_pulse_out_o)
    else $error("pin pulse missing after main wrap");

  chk_pulse_needs_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    timer_pulse_out_o |-> $past(main_wrap))
    else $error("pin pulse without main wrap");

  chk_flag_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_flag_clear_i && !main_wrap |=> !irq_flag_o)
    else $error("irq flag not cleared");

  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_flag_o && !irq_flag_clear_i |=> irq_flag_o)
    else $error("irq flag dropped without clear");

  chk_flag_rise_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(irq_flag_o) |-> $past(main_wrap))
    else $error("irq flag set without main wrap");

  chk_reload_no_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reload_bit_i |=> !timer_irq_o)
    else $error("irq raised by a reload strobe");

  chk_period_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    period_we_i |=> period_value_o == $past(period_value_i))
    else $error("period value not stored");

  chk_stop_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stop_bit_we_i |=> stop_bit_o == $past(stop_bit_i))
    else $error("stop bit not stored");

  chk_main_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    main_count_o != $past(main_count_o) |-> $past(tick) || $past(reload_bit_i))
    else $error("main count moved without prescale wrap");
endmodule

// ==== testbench/test_prescaled_down_timer.sv ====
/*
  self-checking bench for the prescaled down timer.
  assumes the design package is compiled first; inputs change at falling edges.
*/
`timescale 1ns/100ps
module test_prescaled_down_timer;
  // ==========================================================
  // signals and design
  logic clk_i, rst_n_i, period_we_i, prescale_reload_we_i, stop_bit_we_i, stop_bit_i;
  logic reload_bit_i, irq_flag_clear_i;
  logic [15:0] period_value_i, main_count_o, period_value_o;
  logic [3:0] prescale_reload_i, prescale_counter_o, prescale_reload_o;
  logic stop_bit_o, reload_bit_o, irq_flag_o, timer_irq_o, timer_pulse_out_o;
  int num_errors = 0;
  int compares = 0;
  int n;
  logic [15:0] held_main;
  logic [3:0] held_psc;
  logic seen_irq;
  typedef struct packed {logic [3:0] ps; logic [15:0] per; logic [15:0] gap;} row_type;
  row_type rows [5] = '{{4'h0, 16'h0000, 16'h0001}, {4'h0, 16'h0002, 16'h0003},
    {4'h3, 16'h0001, 16'h0008}, {4'hf, 16'h0003, 16'h0040}, {4'h2, 16'h0000, 16'h0003}};
  prescaled_down_timer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .period_we_i(period_we_i),
    .period_value_i(period_value_i), .prescale_reload_we_i(prescale_reload_we_i),
    .prescale_reload_i(prescale_reload_i), .stop_bit_we_i(stop_bit_we_i), .stop_bit_i(stop_bit_i),
    .reload_bit_i(reload_bit_i), .irq_flag_clear_i(irq_flag_clear_i), .main_count_o(main_count_o),
    .prescale_counter_o(prescale_counter_o), .period_value_o(period_value_o),
    .prescale_reload_o(prescale_reload_o), .stop_bit_o(stop_bit_o), .reload_bit_o(reload_bit_o),
    .irq_flag_o(irq_flag_o), .timer_irq_o(timer_irq_o), .timer_pulse_out_o(timer_pulse_out_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wait_irq;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (timer_irq_o !== 1'b1 && n < 2000);
    if (timer_irq_o !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  task do_reset(input int cycles);
    rst_n_i = 1'b0;
    repeat (cycles) @(negedge clk_i);
    check("main", main_count_o, down_timer_pkg::COUNT_RST);
    check("psc", 16'(prescale_counter_o), 16'h0000);
    check("reload", 16'(prescale_reload_o), 16'h0000);
    check("stop", 16'(stop_bit_o), 16'h0000);
    check("flag", 16'(irq_flag_o), 16'h0000);
    check("period", period_value_o, down_timer_pkg::PERIOD_RST);
    check("irq", 16'(timer_irq_o), 16'h0000);
    check("pin", 16'(timer_pulse_out_o), 16'h0000);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check("run", main_count_o, 16'hfffe);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {period_we_i, prescale_reload_we_i, stop_bit_we_i, stop_bit_i, reload_bit_i} = 5'h00;
    irq_flag_clear_i = 1'b0;
    period_value_i = 16'h0000;
    prescale_reload_i = 4'h0;
    do_reset(6);
    foreach (rows[i]) begin
      {period_we_i, prescale_reload_we_i} = 2'h3;
      period_value_i = rows[i].per;
      prescale_reload_i = rows[i].ps;
      @(negedge clk_i);
      {period_we_i, prescale_reload_we_i, reload_bit_i, irq_flag_clear_i} = 4'h3;
      @(negedge clk_i);
      {reload_bit_i, irq_flag_clear_i} = 2'h0;
      check("load main", main_count_o, rows[i].per);
      check("load psc", 16'(prescale_counter_o), 16'(rows[i].ps));
      check("strobe", 16'(reload_bit_o), 16'h0000);
      check("cleared", 16'(irq_flag_o), 16'h0000);
      check("period", period_value_o, rows[i].per);
      check("ps field", 16'(prescale_reload_o), 16'(rows[i].ps));
      repeat (2) begin
        wait_irq();
        check("gap", 16'(n), rows[i].gap);
        check("pulse", 16'(timer_pulse_out_o), 16'h0001);
        check("flag", 16'(irq_flag_o), 16'h0001);
        check("wrap main", main_count_o, rows[i].per);
        check("wrap psc", 16'(prescale_counter_o), 16'(rows[i].ps));
      end
    end
    {stop_bit_we_i, stop_bit_i} = 2'h3;
    @(negedge clk_i);
    stop_bit_we_i = 1'b0;
    check("stop set", 16'(stop_bit_o), 16'h0001);
    held_main = main_count_o;
    held_psc = prescale_counter_o;
    seen_irq = 1'b0;
    repeat (20) begin
      @(negedge clk_i);
      seen_irq = seen_irq | timer_irq_o | timer_pulse_out_o;
    end
    check("stopped irq", 16'(seen_irq), 16'h0000);
    check("held main", main_count_o, held_main);
    check("held psc", 16'(prescale_counter_o), 16'(held_psc));
    {stop_bit_we_i, stop_bit_i} = 2'h2;
    @(negedge clk_i);
    stop_bit_we_i = 1'b0;
    check("stop clear", 16'(stop_bit_o), 16'h0000);
    wait_irq();
    check("restart", 16'(n), 16'h0002);
    irq_flag_clear_i = 1'b1;
    @(negedge clk_i);
    irq_flag_clear_i = 1'b0;
    check("flag clear", 16'(irq_flag_o), 16'h0000);
    @(negedge clk_i);
    irq_flag_clear_i = 1'b1;
    @(negedge clk_i);
    irq_flag_clear_i = 1'b0;
    check("set wins", 16'(irq_flag_o), 16'h0001);
    check("wrap irq", 16'(timer_irq_o), 16'h0001);
    do_reset(2);
    results();
  end
endmodule
